// File: metcfg_consts.svh
// Offsets, field positions, reset values and timing counts of the metering config block
`ifndef METCFG_CONSTS_SVH
`define METCFG_CONSTS_SVH
`define METCFG_ADDR_GENERAL_CONFIG 16'h0481
`define METCFG_ADDR_PULSE_MODE     16'h0490
`define METCFG_BURST_LO            16'h0500
`define METCFG_BURST_HI            16'h06ff
`define METCFG_GC_EXTERNAL_REFERENCE_SELECT          15
`define METCFG_GC_COMBINE          12
`define METCFG_GC_BURST            11
`define METCFG_GC_SETTLE_HI        9
`define METCFG_GC_SETTLE_LO        8
`define METCFG_GC_ACC_CLR          5
`define METCFG_GC_PIN4_HI          3
`define METCFG_GC_PIN4_LO          2
`define METCFG_GC_PIN3             1
`define METCFG_GC_SOFTWARE_RESET_TRIGGER            0
`define METCFG_PM_DIS_LO           12
`define METCFG_PM_DIS_HI           15
`define METCFG_GC_RESET            16'h0000
`define METCFG_PM_RESET            16'h0000
`define METCFG_CLK_KHZ             100000
`define METCFG_SETTLE_A_MS         64
`define METCFG_SETTLE_B_MS         128
`define METCFG_SETTLE_C_MS         256
`define METCFG_PULSE_MS            80
`define METCFG_SETTLE_A_CYC        (`METCFG_SETTLE_A_MS * `METCFG_CLK_KHZ)
`define METCFG_SETTLE_B_CYC        (`METCFG_SETTLE_B_MS * `METCFG_CLK_KHZ)
`define METCFG_SETTLE_C_CYC        (`METCFG_SETTLE_C_MS * `METCFG_CLK_KHZ)
`define METCFG_PULSE_CYC           (`METCFG_PULSE_MS * `METCFG_CLK_KHZ)
`endif

// File: metcfg_host_model.sv
// Host side issuing register cycles to the config block
`timescale 1ns/1ps
module metcfg_host_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] rdata_in,
  output logic [15:0]      addr_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic [15:0]      wdata_out
);
  initial begin
    addr_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 16'h0000;
  end
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    // Released data does not keep its old value
    wdata_out <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1;
    d = rdata_in;
  endtask
endmodule

// File: metcfg_pkg.sv
// Types shared by the metering config block
package metcfg_pkg;
  typedef enum logic [1:0] {
    METCFG_SETTLE_64,
    METCFG_SETTLE_128,
    METCFG_SETTLE_256,
    METCFG_SETTLE_NONE
  } metcfg_settle_t;
  typedef enum logic [1:0] {
    METCFG_P4_DFC0,
    METCFG_P4_DFC1,
    METCFG_P4_EVENT,
    METCFG_P4_IDLE
  } metcfg_pin4_src_t;
  typedef enum {
    METCFG_ST_IDLE,
    METCFG_ST_WAIT,
    METCFG_ST_RUN
  } metcfg_run_state_t;
endpackage

// File: metcfg_pulse_gen.sv
// One active-low pulse pin stretcher with disable and status gating
`timescale 1ns/1ps
module metcfg_pulse_gen #(
  parameter int unsigned WIDTH_CYC = 8000000
) (
  input  wire logic ref_clk_in,
  input  wire logic nrst_in,
  input  wire logic clear_in,
  input  wire logic trig_in,
  input  wire logic disable_in,
  output logic      pin_n_out,
  output logic      status_out
);
  localparam int CW = $clog2(WIDTH_CYC + 1);
  logic [CW-1:0] cnt_reg;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_reg <= '0;
    end else if (clear_in || disable_in) begin
      cnt_reg <= '0;
    end else if (trig_in) begin
      cnt_reg <= CW'(WIDTH_CYC);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_n_out <= 1'b1;
    end else if (clear_in || disable_in) begin
      pin_n_out <= 1'b1;
    end else if (trig_in) begin
      pin_n_out <= 1'b0;
    end else begin
      pin_n_out <= (cnt_reg <= CW'(1));
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_out <= 1'b0;
    end else begin
      status_out <= trig_in && !disable_in && !clear_in;
    end
  end

  dis_pin_high_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    disable_in |=> pin_n_out) else $error("Disabled pulse pin not high");
  dis_no_status_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    disable_in |=> !status_out) else $error("Status flagged on disabled pin");
  pulse_low_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (trig_in && !disable_in && !clear_in) |=> !pin_n_out) else $error("Pulse did not go low");
endmodule

// File: metcfg_top.sv
// Metering configuration and pulse output control registers
`timescale 1ns/1ps
`include "metcfg_consts.svh"
module metcfg_top
  import metcfg_pkg::*;
#(
  parameter int unsigned SETTLE_A_CYC = `METCFG_SETTLE_A_CYC,
  parameter int unsigned SETTLE_B_CYC = `METCFG_SETTLE_B_CYC,
  parameter int unsigned SETTLE_C_CYC = `METCFG_SETTLE_C_CYC,
  parameter int unsigned PULSE_CYC    = `METCFG_PULSE_CYC,
  parameter int unsigned PINS         = 4
) (
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic [15:0] reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic [15:0] spi_rd_addr_in,
  input  wire logic        irq_a_events_in,
  input  wire logic        irq_b_events_in,
  input  wire logic        accum_start_in,
  input  wire logic [3:0]  dfc_pulse_in,
  input  wire logic        event_in,
  input  wire logic        zero_cross_in,
  output logic [15:0]      reg_rdata_out,
  output logic             external_reference_select_out,
  output logic             interrupt_pin_a_n_out,
  output logic             interrupt_pin_b_n_out,
  output logic             burst_read_ok_out,
  output logic             crc_append_out,
  output logic             accum_run_out,
  output logic             pulse_accumulator_clear_out,
  output logic             software_reset_out,
  output logic [3:0]       pulse_pin_n_out,
  output logic [3:0]       pulse_status_flag_out
);
  logic             external_reference_select_reg;
  logic             combine_reg;
  logic             burst_reg;
  metcfg_settle_t   settle_reg;
  metcfg_pin4_src_t pin4_src_reg;
  logic             pin3_src_reg;
  logic [3:0]       pin_dis_reg;
  logic             acc_clr_reg;
  logic             software_reset_trigger_reg;
  logic             wr_gc;
  logic             wr_pm;
  logic [3:0]       gen_pin_n;
  logic [3:0]       gen_status;
  metcfg_run_state_t run_state_reg;
  logic [31:0]      settle_cnt_reg;
  logic [31:0]      settle_target;

  function automatic logic addr_is(input logic [15:0] a, input logic [15:0] ref_a);
    addr_is = (a == ref_a);
  endfunction

  assign wr_gc = reg_wr_in && addr_is(reg_addr_in, `METCFG_ADDR_GENERAL_CONFIG);
  assign wr_pm = reg_wr_in && addr_is(reg_addr_in, `METCFG_ADDR_PULSE_MODE);

  // Configuration fields of general config
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      external_reference_select_reg  <= 1'b0;
      combine_reg  <= 1'b0;
      burst_reg    <= 1'b0;
      settle_reg   <= METCFG_SETTLE_64;
      pin4_src_reg <= METCFG_P4_DFC0;
      pin3_src_reg <= 1'b0;
    end else if (software_reset_trigger_reg) begin
      external_reference_select_reg  <= 1'b0;
      combine_reg  <= 1'b0;
      burst_reg    <= 1'b0;
      settle_reg   <= METCFG_SETTLE_64;
      pin4_src_reg <= METCFG_P4_DFC0;
      pin3_src_reg <= 1'b0;
    end else if (wr_gc) begin
      external_reference_select_reg  <= reg_wdata_in[`METCFG_GC_EXTERNAL_REFERENCE_SELECT];
      combine_reg  <= reg_wdata_in[`METCFG_GC_COMBINE];
      burst_reg    <= reg_wdata_in[`METCFG_GC_BURST];
      settle_reg   <= metcfg_settle_t'(reg_wdata_in[`METCFG_GC_SETTLE_HI:`METCFG_GC_SETTLE_LO]);
      pin4_src_reg <= metcfg_pin4_src_t'(reg_wdata_in[`METCFG_GC_PIN4_HI:`METCFG_GC_PIN4_LO]);
      pin3_src_reg <= reg_wdata_in[`METCFG_GC_PIN3];
    end
  end

  // Pulse pin disables
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_dis_reg <= 4'(`METCFG_PM_RESET >> `METCFG_PM_DIS_LO);
    end else if (software_reset_trigger_reg) begin
      pin_dis_reg <= 4'h0;
    end else if (wr_pm) begin
      pin_dis_reg <= reg_wdata_in[`METCFG_PM_DIS_HI:`METCFG_PM_DIS_LO];
    end
  end

  // Self-clearing strobes
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_clr_reg <= 1'b0;
      software_reset_trigger_reg   <= 1'b0;
    end else begin
      acc_clr_reg <= wr_gc && reg_wdata_in[`METCFG_GC_ACC_CLR] && !software_reset_trigger_reg;
      software_reset_trigger_reg   <= wr_gc && reg_wdata_in[`METCFG_GC_SOFTWARE_RESET_TRIGGER] && !software_reset_trigger_reg;
    end
  end

  // Read data, write-only and reserved bits read zero
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in && addr_is(reg_addr_in, `METCFG_ADDR_GENERAL_CONFIG)) begin
      reg_rdata_out <= {external_reference_select_reg, 2'h0, combine_reg, burst_reg, 1'h0, settle_reg, 4'h0,
                        pin4_src_reg, pin3_src_reg, 1'h0};
    end else if (reg_rd_in && addr_is(reg_addr_in, `METCFG_ADDR_PULSE_MODE)) begin
      reg_rdata_out <= {pin_dis_reg, 12'h000};
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

  // Interrupt pins, active low
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      interrupt_pin_a_n_out <= 1'b1;
      interrupt_pin_b_n_out <= 1'b1;
    end else begin
      interrupt_pin_a_n_out <= !irq_a_events_in;
      interrupt_pin_b_n_out <= !(irq_b_events_in || (combine_reg && irq_a_events_in));
    end
  end

  // Burst window and CRC suppression
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      burst_read_ok_out <= 1'b0;
      crc_append_out    <= 1'b1;
    end else begin
      burst_read_ok_out <= burst_reg && spi_rd_addr_in >= `METCFG_BURST_LO
                           && spi_rd_addr_in <= `METCFG_BURST_HI;
      crc_append_out    <= !burst_reg;
    end
  end

  always_comb begin
    case (settle_reg)
      METCFG_SETTLE_64:   settle_target = SETTLE_A_CYC;
      METCFG_SETTLE_128:  settle_target = SETTLE_B_CYC;
      METCFG_SETTLE_256:  settle_target = SETTLE_C_CYC;
      METCFG_SETTLE_NONE: settle_target = 32'h0000_0000;
      default:            settle_target = 32'h0000_0000;
    endcase
  end

  // Settle wait before accumulation
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_state_reg  <= METCFG_ST_IDLE;
      settle_cnt_reg <= 32'h0000_0000;
    end else if (!accum_start_in || software_reset_trigger_reg) begin
      run_state_reg  <= METCFG_ST_IDLE;
      settle_cnt_reg <= 32'h0000_0000;
    end else begin
      case (run_state_reg)
        METCFG_ST_IDLE: begin
          settle_cnt_reg <= 32'h0000_0000;
          run_state_reg  <= METCFG_ST_WAIT;
        end
        METCFG_ST_WAIT: begin
          if (settle_cnt_reg >= settle_target) begin
            run_state_reg <= METCFG_ST_RUN;
          end else begin
            settle_cnt_reg <= settle_cnt_reg + 32'h0000_0001;
          end
        end
        METCFG_ST_RUN: run_state_reg <= METCFG_ST_RUN;
        default: run_state_reg <= METCFG_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      accum_run_out <= 1'b0;
    end else begin
      accum_run_out <= accum_start_in && !software_reset_trigger_reg && run_state_reg == METCFG_ST_RUN;
    end
  end

  generate
    for (genvar i = 0; i < PINS; i++) begin : g_pin
      metcfg_pulse_gen #(
        .WIDTH_CYC (PULSE_CYC)
      ) u_gen (
        .ref_clk_in (ref_clk_in),
        .nrst_in    (nrst_in),
        .clear_in   (acc_clr_reg),
        .trig_in    (dfc_pulse_in[i] && accum_run_out),
        .disable_in (pin_dis_reg[i]),
        .pin_n_out  (gen_pin_n[i]),
        .status_out (gen_status[i])
      );
    end
  endgenerate

  // Pin source muxing, disabled pins held high
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pulse_pin_n_out       <= 4'hf;
      pulse_status_flag_out <= 4'h0;
    end else begin
      pulse_status_flag_out <= gen_status;
      pulse_pin_n_out[1:0]  <= gen_pin_n[1:0];
      if (pin_dis_reg[2]) begin
        pulse_pin_n_out[2] <= 1'b1;
      end else begin
        pulse_pin_n_out[2] <= pin3_src_reg ? zero_cross_in : gen_pin_n[2];
      end
      if (pin_dis_reg[3]) begin
        pulse_pin_n_out[3] <= 1'b1;
      end else begin
        case (pin4_src_reg)
          METCFG_P4_DFC0:  pulse_pin_n_out[3] <= gen_pin_n[3];
          METCFG_P4_DFC1:  pulse_pin_n_out[3] <= gen_pin_n[3];
          METCFG_P4_EVENT: pulse_pin_n_out[3] <= event_in;
          default:         pulse_pin_n_out[3] <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      external_reference_select_out <= 1'b0;
      pulse_accumulator_clear_out   <= 1'b0;
      software_reset_out            <= 1'b0;
    end else begin
      external_reference_select_out <= external_reference_select_reg;
      pulse_accumulator_clear_out   <= acc_clr_reg;
      software_reset_out            <= software_reset_trigger_reg;
    end
  end

  combine_pin_b_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (combine_reg && irq_a_events_in) |=> !interrupt_pin_b_n_out) else $error("Pin B missed combined event");
  pin_a_own_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    irq_a_events_in |=> !interrupt_pin_a_n_out) else $error("Pin A missed own event");
  crc_off_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    burst_reg |=> !crc_append_out) else $error("CRC appended in burst mode");
  acc_clr_self_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (acc_clr_reg && !(wr_gc && reg_wdata_in[`METCFG_GC_ACC_CLR])) |=> !acc_clr_reg)
    else $error("Accumulator clear did not self-clear");
  software_reset_trigger_fields_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    software_reset_trigger_reg |=> (!combine_reg && !burst_reg && pin_dis_reg == 4'h0 && !software_reset_trigger_reg))
    else $error("Software reset left fields set");
  pin4_dis_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    pin_dis_reg[3] |=> pulse_pin_n_out[3]) else $error("Pin 4 low while disabled");
  settle_none_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (settle_reg == METCFG_SETTLE_NONE && !software_reset_trigger_reg && accum_start_in && run_state_reg == METCFG_ST_IDLE)
    ##1 (accum_start_in && !software_reset_trigger_reg && settle_reg == METCFG_SETTLE_NONE)[*2]
    |=> accum_run_out) else $error("Zero settle did not start at once");
  pin3_zx_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (pin3_src_reg && !pin_dis_reg[2]) |=> pulse_pin_n_out[2] == $past(zero_cross_in))
    else $error("Pin 3 not following zero crossing");
endmodule

// File: tb.sv
// Self-checking bench for the metering config block
`timescale 1ns/1ps
module tb;
  logic        clk, nrst, rd, wr, ia, ib, start, ev, zc;
  logic        ext, pa, pb, bok, crc, run, clr, swr;
  logic [15:0] addr, wd, sa, rdat, v;
  logic [3:0]  dfc, pin_n, flag;
  int          n_mismatch, compares, n, k;
  int          tgt [4] = '{20, 40, 80, 0};
  int          cnt [4];
  logic [15:0] rows [6][3] = '{
    '{16'h0481, 16'hfffe, 16'h9b0e}, '{16'h0481, 16'h0000, 16'h0000},
    '{16'h0481, 16'h6cf0, 16'h0800}, '{16'h0490, 16'hffff, 16'hf000},
    '{16'h0490, 16'h5000, 16'h5000}, '{16'h0482, 16'hffff, 16'h0000}};
  logic [15:0] bur [4][2] = '{'{16'h04ff, 0}, '{16'h0500, 1}, '{16'h06ff, 1}, '{16'h0700, 0}};

  metcfg_top #(.SETTLE_A_CYC(20), .SETTLE_B_CYC(40), .SETTLE_C_CYC(80), .PULSE_CYC(10)) dut_u (
    .ref_clk_in(clk), .nrst_in(nrst), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wd), .spi_rd_addr_in(sa), .irq_a_events_in(ia), .irq_b_events_in(ib),
    .accum_start_in(start), .dfc_pulse_in(dfc), .event_in(ev), .zero_cross_in(zc),
    .reg_rdata_out(rdat), .external_reference_select_out(ext), .interrupt_pin_a_n_out(pa),
    .interrupt_pin_b_n_out(pb), .burst_read_ok_out(bok), .crc_append_out(crc),
    .accum_run_out(run), .pulse_accumulator_clear_out(clr), .software_reset_out(swr),
    .pulse_pin_n_out(pin_n), .pulse_status_flag_out(flag));
  metcfg_host_model host_u (.clk_in(clk), .rdata_in(rdat), .addr_out(addr), .wr_out(wr),
    .rd_out(rd), .wdata_out(wd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic wait_hi(ref logic s);
    n = 0;
    while (s !== 1'b1 && n < 6) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic give_verdict();
    $display("n_mismatch %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    {ia, ib, start, ev, zc} = 5'h00;
    sa = 16'h0000;
    dfc = 4'h0;
    repeat (12) @(posedge clk);
    chk("reset pins", 16'h001f, {11'h0, pin_n, crc});
    chk("reset outs", 16'h0300, {5'h0, ext, pa, pb, bok, run, clr, swr, flag});
    nrst <= 1'b1;
    cyc(1);
    chk("after reset", 16'h0000, rdat);
    for (k = 0; k < 6; k++) begin
      host_u.wr(rows[k][0], rows[k][1]);
      host_u.rd(rows[k][0], v);
      chk("readback", rows[k][2], v);
      if (rows[k][0] == 16'h0481) begin
        chk("external_reference_select", {15'h0, rows[k][1][15]}, {15'h0, ext});
        chk("crc", {15'h0, !rows[k][1][11]}, {15'h0, crc});
      end
    end
    host_u.wr(16'h0481, 16'h0800);
    for (k = 0; k < 4; k++) begin
      sa <= bur[k][0];
      cyc(3);
      chk("burst ok", bur[k][1], {15'h0, bok});
    end
    for (k = 0; k < 8; k++) begin
      if (k % 4 == 0) host_u.wr(16'h0481, 16'((k / 4) << 12));
      @(posedge clk) {ia, ib} <= 2'(k);
      cyc(3);
      chk("irq a", {15'h0, !k[1]}, {15'h0, pa});
      chk("irq b", {15'h0, !(k[0] | (k[2] & k[1]))}, {15'h0, pb});
    end
    for (k = 0; k < 4; k++) begin
      @(posedge clk) start <= 1'b0;
      cyc(2);
      chk("run drop", 16'h0000, {15'h0, run});
      host_u.wr(16'h0481, 16'(k) << 8);
      @(posedge clk) start <= 1'b1;
      n = 0;
      while (run !== 1'b1 && n < 200) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk("settle", 16'(tgt[k] + 3), 16'(n));
    end
    host_u.wr(16'h0490, 16'h2000);
    @(posedge clk) dfc <= 4'h3;
    @(posedge clk) dfc <= 4'h0;
    cnt = '{0, 0, 0, 0};
    repeat (20) begin
      @(posedge clk);
      #1;
      cnt[0] += int'(pin_n[0] === 1'b0);
      cnt[1] += int'(pin_n[1] === 1'b0);
      cnt[2] += int'(flag[0] === 1'b1);
      cnt[3] += int'(flag[1] === 1'b1);
    end
    chk("pin1 low", 16'd10, 16'(cnt[0]));
    chk("pin2 low", 16'd0, 16'(cnt[1]));
    chk("flag1", 16'd1, 16'(cnt[2]));
    chk("flag2", 16'd0, 16'(cnt[3]));
    @(posedge clk) dfc <= 4'h1;
    @(posedge clk) dfc <= 4'h0;
    host_u.wr(16'h0481, 16'h0320);
    wait_hi(clr);
    chk("clear", 16'h0001, {15'h0, clr});
    cyc(3);
    chk("clear aborts", 16'h0001, {15'h0, pin_n[0]});
    host_u.rd(16'h0481, v);
    chk("clear self", 16'h0300, v);
    host_u.wr(16'h0481, 16'h030a);
    for (k = 0; k < 2; k++) begin
      @(posedge clk) {ev, zc} <= {k[0], !k[0]};
      cyc(3);
      chk("pin4 pin3 src", {14'h0, k[0], !k[0]}, {14'h0, pin_n[3:2]});
    end
    @(posedge clk) {ev, zc} <= 2'b00;
    host_u.wr(16'h0481, 16'h0304);
    @(posedge clk) dfc <= 4'hc;
    @(posedge clk) dfc <= 4'h0;
    cyc(3);
    chk("pin4 pin3 dfc", 16'h0000, {14'h0, pin_n[3:2]});
    host_u.wr(16'h0490, 16'hc000);
    cyc(3);
    chk("pins disabled", 16'h0003, {14'h0, pin_n[3:2]});
    host_u.wr(16'h0490, 16'h0000);
    host_u.wr(16'h0481, 16'h030e);
    cyc(3);
    chk("pin4 code 11", 16'h0001, {15'h0, pin_n[3]});
    host_u.wr(16'h0490, 16'hf000);
    host_u.wr(16'h0481, 16'h9b0f);
    wait_hi(swr);
    chk("sw reset", 16'h0001, {15'h0, swr});
    cyc(2);
    host_u.rd(16'h0481, v);
    chk("cfg cleared", 16'h0000, v);
    host_u.rd(16'h0490, v);
    chk("mode cleared", 16'h0000, v);
    give_verdict();
  end
endmodule
